// ---- wu_pkg.sv ----
/*
  Package for the oscillator warm-up counter: control field positions,
  mode and clock-select codes, the state and control carriers.
  Assumes the control bytes are held by logic on the same clock.
*/
package wu_pkg;

  // control byte fields
  localparam int FF_INIT_BIT   = 7;      // flipflop_init_bit position
  localparam int RUN_BIT       = 3;      // timer_run_bit position
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int CLKSEL_LSB    = 4;
  localparam int CLKSEL_MSB    = 6;

  // mode codes (upper and lower control)
  localparam logic [2:0] MODE_WARMUP  = 3'h5;  // upper timer
  localparam logic [2:0] MODE_CASCADE = 3'h3;  // lower timer, 16-bit
  // source clock select codes (lower control)
  localparam logic [2:0] CLK_LOW      = 3'h4;  // low_freq_clock
  localparam logic [2:0] CLK_HIGH     = 3'h6;  // high_freq_clock

  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0]  SYNC_RST  = 2'h0;

  // nominal source rates, for reference of warm-up span
  localparam int LOW_FREQ_HZ   = 32768;
  localparam int TICKS_PER_STEP = 256;  // one compare step = 256 ticks

  // software-held control bytes
  typedef struct packed {
    logic [7:0] upper_timer_control;
    logic [7:0] lower_timer_control;
    logic [7:0] warmup_compare_high;
    logic [7:0] warmup_compare_low;
  } wu_ctrl_t;

  // main block state
  typedef struct packed {
    logic [15:0] count;
    logic        irq;
  } wu_state_t;

  // source edge detector state
  typedef struct packed {
    logic [1:0] sync_lo;
    logic [1:0] sync_hi;
    logic       prev_lo;
    logic       prev_hi;
    logic       tick;
  } wu_tick_state_t;

endpackage

// ---- wu_src_tick.sv ----
/*
  Source clock edge detector: synchronises both oscillator pins and turns
  a rising edge of the selected one into a one-cycle tick enable.
  Assumes the source clocks are well below half of clk.
*/
`timescale 1ns/1ps
module wu_src_tick import wu_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // oscillator pins
  input  wire logic       high_freq_clock,
  input  wire logic       low_freq_clock,
  // selection and result
  input  wire logic [2:0] clk_sel,
  output logic            tick
);

  wu_tick_state_t s_q;
  wu_tick_state_t s_d;

  // edge detectors read only the second sync stage
  always_comb begin
    s_d         = s_q;
    s_d.sync_lo = {s_q.sync_lo[0], low_freq_clock};
    s_d.sync_hi = {s_q.sync_hi[0], high_freq_clock};
    s_d.prev_lo = s_q.sync_lo[1];
    s_d.prev_hi = s_q.sync_hi[1];
    case (clk_sel)
      CLK_LOW:  s_d.tick = s_q.sync_lo[1] & ~s_q.prev_lo;
      CLK_HIGH: s_d.tick = s_q.sync_hi[1] & ~s_q.prev_hi;
      default:  s_d.tick = 1'b0;  // other sources outside this mode
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{sync_lo: SYNC_RST, sync_hi: SYNC_RST, prev_lo: 1'b0,
               prev_hi: 1'b0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// ---- wu_counter.sv ----
/*
  Oscillator warm-up counter: two cascaded 8-bit timers as one 16-bit
  up-counter clocked by the selected oscillator, matched on its upper byte.
  The counter measures how long a freshly started oscillator is left to
  settle before software moves the system clock onto it, in either
  direction between the fast and the slow source.
  Assumes control bytes come from register logic on clk, and that both
  oscillator pins are slow square waves that need synchronising here.
  Assumes the oscillator enables and the system clock select live outside
  this block and are sequenced by software around the match interrupt.
*/
`timescale 1ns/1ps
module wu_counter import wu_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // oscillator pins
  input  wire logic        high_freq_clock,
  input  wire logic        low_freq_clock,
  // software control
  input  wire wu_ctrl_t    ctrl,
  // status
  output logic             warmup_match_irq,
  output logic [15:0]      warmup_count,
  output logic             warmup_running
);

  wu_state_t   s_q;
  wu_state_t   s_d;
  logic        tick;
  logic        mode_ok;
  logic        run;
  logic [15:0] count_inc;
  logic [2:0]  clk_sel;

  assign clk_sel = ctrl.lower_timer_control[CLKSEL_MSB:CLKSEL_LSB];

  // the selected source drives the count; slow or fast use
  wu_src_tick u_tick (
    .clk             (clk),
    .arst_n          (arst_n),
    .high_freq_clock (high_freq_clock),
    .low_freq_clock  (low_freq_clock),
    .clk_sel         (clk_sel),
    .tick            (tick)
  );

  // warm-up needs upper in warm-up mode and lower in 16-bit cascade
  assign mode_ok =
    (ctrl.upper_timer_control[MODE_MSB:MODE_LSB] == MODE_WARMUP) &&
    (ctrl.lower_timer_control[MODE_MSB:MODE_LSB] == MODE_CASCADE);
  assign run = mode_ok && ctrl.upper_timer_control[RUN_BIT];

  assign count_inc = s_q.count + 16'h0001;  // low byte carries up

  // counting, match and stop; the initial-value bits are not used here,
  // so a stray 1 cannot disturb the count, only pins elsewhere
  always_comb begin
    s_d     = s_q;
    s_d.irq = 1'b0;
    if (!run) begin
      s_d.count = COUNT_RST;  // stop clears at once
    end else if (tick) begin
      // 256 ticks per compare step sets the span on either source
      if (count_inc[15:8] == ctrl.warmup_compare_high) begin
        s_d.count = COUNT_RST;
        s_d.irq   = 1'b1;
      end else begin
        s_d.count = count_inc;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{count: COUNT_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign warmup_match_irq = s_q.irq;
  assign warmup_count     = s_q.count;
  assign warmup_running   = run;

  // checks

  AST_STOP_CLEARS: assert property (
    @(posedge clk) disable iff (!arst_n)
    !run |=> (s_q.count == COUNT_RST) && !s_q.irq)
    else $error("count not cleared or irq while stopped");

  AST_IRQ_NEEDS_RUN: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.irq |-> $past(run) && $past(tick))
    else $error("irq without running tick");

  AST_IRQ_CLEARS: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(s_q.irq) |-> s_q.count == COUNT_RST)
    else $error("counter not cleared on match");

  AST_MATCH_UPPER: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (count_inc[15:8] == ctrl.warmup_compare_high)
    |=> s_q.irq)
    else $error("upper byte match missed");

  AST_INCREMENT: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (count_inc[15:8] != ctrl.warmup_compare_high)
    |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("counter did not step by one");

  AST_HOLD: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && !tick |=> s_q.count == $past(s_q.count) && !s_q.irq)
    else $error("counter moved without a source edge");

  AST_IRQ_PULSE: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.irq |=> !s_q.irq)
    else $error("irq longer than one cycle");

  AST_MODE_GATE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !mode_ok [*2] |-> s_q.count == COUNT_RST)
    else $error("counter active outside warm-up mode");

  // a tick only comes from one of the two oscillator selections
  AST_TICK_NEEDS_SEL: assert property (
    @(posedge clk) disable iff (!arst_n)
    tick |-> ($past(clk_sel) == CLK_LOW) || ($past(clk_sel) == CLK_HIGH))
    else $error("tick from an unsupported source");

  // the interrupt always comes with a cleared counter
  AST_IRQ_COUNT_ZERO: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.irq |-> s_q.count == COUNT_RST)
    else $error("irq with counter not cleared");

  // no interrupt in the cycle after a stopped one
  AST_NO_IRQ_STOPPED: assert property (
    @(posedge clk) disable iff (!arst_n)
    !$past(run) |-> !s_q.irq)
    else $error("irq after timer stopped");

  // the match looks at the upper compare byte only
  AST_IRQ_ON_MATCH: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.irq |-> $past(count_inc[15:8]) == $past(ctrl.warmup_compare_high))
    else $error("irq without upper byte match");

  // a mismatch on a tick never raises the interrupt
  AST_NO_MATCH_NO_IRQ: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (count_inc[15:8] != ctrl.warmup_compare_high)
    |=> !s_q.irq)
    else $error("irq without match");

  // low byte wraps and carries one into the high byte
  AST_CARRY: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (s_q.count[7:0] == 8'hFF) &&
    (count_inc[15:8] != ctrl.warmup_compare_high)
    |=> (s_q.count[7:0] == 8'h00) &&
        (s_q.count[15:8] == $past(s_q.count[15:8]) + 8'h01))
    else $error("carry into high byte wrong");

  // without a carry the high byte stays put unless a match clears the counter
  AST_NO_CARRY: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (s_q.count[7:0] != 8'hFF)
    |=> s_q.count[15:8] == $past(s_q.count[15:8]) || s_q.irq)
    else $error("high byte moved without carry");

  // a match clears the counter on the next edge
  AST_MATCH_CLEARS: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && tick && (count_inc[15:8] == ctrl.warmup_compare_high)
    |=> s_q.count == COUNT_RST)
    else $error("match did not clear counter");

  // an unsupported source select holds the count
  AST_BAD_SEL_HOLDS: assert property (
    @(posedge clk) disable iff (!arst_n)
    (run && (clk_sel != CLK_LOW) && (clk_sel != CLK_HIGH)) ##1
    (run && (clk_sel != CLK_LOW) && (clk_sel != CLK_HIGH))
    |=> s_q.count == $past(s_q.count) && !s_q.irq)
    else $error("count moved on unsupported source");

  // the interrupt needs both timers in the warm-up pairing
  AST_IRQ_NEEDS_MODE: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_q.irq |-> $past(mode_ok))
    else $error("irq outside warm-up mode");

endmodule

// ---- tb_wu_counter.sv ----
/*
  Self-checking bench for the oscillator warm-up counter: drives both
  oscillator pins as slow square waves and the control bytes as levels.
  Assumes the counter's own assertions run alongside.
*/
`timescale 1ns/1ps
module tb_wu_counter import wu_pkg::*;;
  logic        clk;
  logic        arst_n;
  logic        high_freq_clock;
  logic        low_freq_clock;
  wu_ctrl_t    ctrl;
  logic        warmup_match_irq;
  logic [15:0] warmup_count;
  logic        warmup_running;
  int          err_count;
  int          n_compared;
  int          irq_seen;

  wu_counter i_dut (
    .clk              (clk),
    .arst_n           (arst_n),
    .high_freq_clock  (high_freq_clock),
    .low_freq_clock   (low_freq_clock),
    .ctrl             (ctrl),
    .warmup_match_irq (warmup_match_irq),
    .warmup_count     (warmup_count),
    .warmup_running   (warmup_running)
  );

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // irq is a one-cycle pulse, so count it on every edge
  always @(posedge clk) begin
    if (warmup_match_irq === 1'b1) irq_seen++;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // source edges: 4 clk high, 4 clk low keeps above the 3-cycle minimum
  task automatic pulses(input logic fast, input int n);
    repeat (n) begin
      if (fast) high_freq_clock = 1'b1;
      else low_freq_clock = 1'b1;
      repeat (4) @(negedge clk);
      high_freq_clock = 1'b0;
      low_freq_clock  = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog well past the roughly 8.3k cycles the tests need
  initial begin
    #800000;
    err_count++;
    conclude();
  end

  initial begin
    err_count = 0;
    n_compared = 0;
    irq_seen = 0;
    arst_n = 1'b0;
    high_freq_clock = 1'b0;
    low_freq_clock = 1'b0;
    ctrl = '0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    check("count", warmup_count, 16'h0000);
    check("irq", 16'(warmup_match_irq), 16'h0000);
    // slow source, compare low byte set to FF to prove it is ignored
    // slow oscillator pin starts pulsing only after the timer starts
    ctrl.warmup_compare_high = 8'h01;
    ctrl.warmup_compare_low  = 8'hFF;
    ctrl.lower_timer_control = 8'h43;
    ctrl.upper_timer_control = 8'h05;
    @(negedge clk);
    ctrl.upper_timer_control = 8'h0D;
    @(negedge clk);
    check("running", 16'(warmup_running), 16'h0001);
    pulses(1'b0, 255);
    check("count", warmup_count, 16'h00FF);
    check("irq_count", 16'(irq_seen), 16'h0000);
    pulses(1'b0, 1);
    check("count", warmup_count, 16'h0000);
    check("irq_count", 16'(irq_seen), 16'h0001);
    // the unselected pin must not count
    pulses(1'b1, 3);
    check("count", warmup_count, 16'h0000);
    pulses(1'b0, 3);
    check("count", warmup_count, 16'h0003);
    // stop clears at once, no irq while stopped
    ctrl.upper_timer_control = 8'h05;
    @(negedge clk);
    check("count", warmup_count, 16'h0000);
    check("running", 16'(warmup_running), 16'h0000);
    pulses(1'b0, 260);
    check("irq_count", 16'(irq_seen), 16'h0001);
    // fast source, match after two carries into the high byte
    ctrl.lower_timer_control = 8'h63;
    ctrl.warmup_compare_high = 8'h02;
    @(negedge clk);
    ctrl.upper_timer_control = 8'h0D;
    pulses(1'b1, 511);
    check("count", warmup_count, 16'h01FF);
    pulses(1'b1, 1);
    check("count", warmup_count, 16'h0000);
    check("irq_count", 16'(irq_seen), 16'h0002);
    // handler stops the timer before touching the clocks
    ctrl.upper_timer_control = 8'h05;
    @(negedge clk);
    check("running", 16'(warmup_running), 16'h0000);
    ctrl.upper_timer_control = 8'h0D;
    pulses(1'b1, 2);
    check("count", warmup_count, 16'h0002);
    // lower timer not in cascade mode refuses to count
    ctrl.lower_timer_control = 8'h62;
    @(negedge clk);
    check("running", 16'(warmup_running), 16'h0000);
    pulses(1'b1, 2);
    check("count", warmup_count, 16'h0000);
    conclude();
  end
endmodule
